// File: include/cpd_pkg.sv
// Purpose: Shared constants and types for the opcode and interrupt decoder
// Assumes: 8-bit opcodes, 16-bit addresses
// Notes:   Vectors and opcode fields are named here once
package cpd_pkg;
   localparam logic [15:0] CPD_VEC_NMI  = 16'h0024;
   localparam logic [15:0] CPD_VEC_RST2 = 16'h003C;
   localparam logic [15:0] CPD_VEC_RST3 = 16'h034C; // Kept as printed
   localparam logic [15:0] CPD_VEC_RST4 = 16'h002C;
   localparam logic [7:0]  CPD_RST_MASK = 8'hC7;    // Restart opcode 11NNN111
   localparam logic [7:0]  CPD_RST_CODE = 8'hC7;
   localparam logic [7:0]  CPD_CALL_OP  = 8'hCD;
   localparam logic [2:0]  CPD_VEC_LSB  = 3'h0;
   localparam logic [2:0]  CPD_REG_B    = 3'h0;
   localparam logic [2:0]  CPD_REG_C    = 3'h1;
   localparam logic [2:0]  CPD_REG_D    = 3'h2;
   localparam logic [2:0]  CPD_REG_E    = 3'h3;
   localparam logic [2:0]  CPD_REG_H    = 3'h4;
   localparam logic [2:0]  CPD_REG_L    = 3'h5;
   localparam logic [2:0]  CPD_REG_MEM  = 3'h6;
   localparam logic [2:0]  CPD_REG_A    = 3'h7;
   localparam logic [1:0]  CPD_GRP_COPY = 2'h1;
   localparam logic [1:0]  CPD_GRP_LOW  = 2'h0;
   localparam logic [1:0]  CPD_GRP_HIGH = 2'h3;
   localparam logic [3:0]  CPD_LOW_PAIR_IMM = 4'h1;
   localparam logic [3:0]  CPD_LOW_PUSH = 4'h5;
   localparam logic [1:0]  CPD_PAIR_AF  = 2'h3;
   localparam logic [1:0]  CPD_IMM_PAIR = 2'h2;    // Bytes that follow a pair load
   localparam int          CPD_NSRC     = 5;
   typedef enum logic [3:0] {
      CPD_OP_NONE, CPD_OP_COPY, CPD_OP_STORE_M, CPD_OP_LOAD_M,
      CPD_OP_LOAD_PAIR_IMM, CPD_OP_PUSH_PAIR, CPD_OP_PUSH_AF, CPD_OP_HALT
   } cpd_op_t;
   typedef enum logic [2:0] {
      CPD_SRC_NONE, CPD_SRC_NMI, CPD_SRC_RST2, CPD_SRC_RST3, CPD_SRC_RST4,
      CPD_SRC_GEN
   } cpd_src_t;
endpackage

// File: include/cpd_sync_if.sv
`timescale 1ns/1ns
// Purpose: Carries raw and synchronised interrupt lines between modules
// Assumes: One clock domain
// Notes:   Width set by the source count
interface cpd_sync_if;
   import cpd_pkg::*;
   logic [CPD_NSRC-1:0] raw;
   logic [CPD_NSRC-1:0] level;
   logic [CPD_NSRC-1:0] rise;
   modport sync_side (input raw, output level, output rise);
   modport user_side (output raw, input level, input rise);
endinterface

// File: verilog/cpd_sync.sv
`timescale 1ns/1ns
// Purpose: Three-stage synchronisers for the interrupt pins
// Assumes: Pins are asynchronous to i_clk
// Notes:   Change accepted once stages two and three agree
module cpd_sync
   import cpd_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   cpd_sync_if.sync_side    s
);
   logic [CPD_NSRC-1:0] st1_reg, st2_reg, st3_reg, lvl_reg;
   logic [CPD_NSRC-1:0] st1_next, st2_next, st3_next, lvl_next;

   // Stage one feeds stage two only
   always_comb begin
      st1_next = s.raw;
      st2_next = st1_reg;
      st3_next = st2_reg;
      lvl_next = lvl_reg;
      for (int i = 0; i < CPD_NSRC; i++) begin
         if (st2_reg[i] == st3_reg[i]) begin
            lvl_next[i] = st3_reg[i];
         end
      end
   end

   // Registers only
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         st1_reg <= '0;
         st2_reg <= '0;
         st3_reg <= '0;
         lvl_reg <= '0;
      end else begin
         st1_reg <= st1_next;
         st2_reg <= st2_next;
         st3_reg <= st3_next;
         lvl_reg <= lvl_next;
      end
   end

   assign s.level = lvl_reg;
   assign s.rise  = lvl_next & ~lvl_reg;
endmodule

// File: verilog/cpd_decode.sv
`timescale 1ns/1ns
// Purpose: Opcode decode and prioritised interrupt resolution for an 8-bit CPU
// Assumes: Opcodes are strobed from the fetch unit; interrupt pins asynchronous
// Notes:   Interrupt is taken on i_int_take from the sequencer
module cpd_decode
   import cpd_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_op_valid,
   input  wire logic [7:0]  i_opcode,
   input  wire logic        i_nmi,
   input  wire logic        i_rst2,
   input  wire logic        i_rst3,
   input  wire logic        i_rst4,
   input  wire logic        i_general_interrupt_request,
   input  wire logic        i_int_enable,
   input  wire logic        i_int_take,
   input  wire logic        i_ack_valid,
   input  wire logic [7:0]  i_ack_opcode,
   input  wire logic [15:0] i_program_counter,
   output logic             o_op_valid,
   output cpd_op_t          o_op,
   output logic [2:0]       o_dst,
   output logic [2:0]       o_src,
   output logic [1:0]       o_pair,
   output logic [1:0]       o_imm_bytes,
   output logic             o_int_pending,
   output logic             o_ack_req,
   output logic             o_push_valid,
   output logic [15:0]      o_push_data,
   output logic             o_jump_valid,
   output logic [15:0]      o_jump_addr
);
   typedef enum logic [1:0] {CPD_ST_IDLE, CPD_ST_ACK, CPD_ST_PUSH, CPD_ST_JUMP} cpd_st_t;

   cpd_sync_if sif ();

   cpd_sync u_sync (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .s         (sif.sync_side)
   );

   assign sif.raw = {i_general_interrupt_request, i_rst4, i_rst3, i_rst2, i_nmi};

   // Restart opcode to its vector, used for supplied instructions
   function automatic logic [15:0] rst_vec(input logic [7:0] op);
      rst_vec = {10'h000, op[5:3], CPD_VEC_LSB};
   endfunction

   // Classify one opcode byte
   function automatic cpd_op_t classify(input logic [7:0] op);
      classify = CPD_OP_NONE;
      if (op[7:6] == CPD_GRP_COPY) begin
         if (op[5:3] == CPD_REG_MEM && op[2:0] == CPD_REG_MEM) begin
            classify = CPD_OP_HALT; // Both memory is not a move
         end else if (op[5:3] == CPD_REG_MEM) begin
            classify = CPD_OP_STORE_M;
         end else if (op[2:0] == CPD_REG_MEM) begin
            classify = CPD_OP_LOAD_M;
         end else begin
            classify = CPD_OP_COPY;
         end
      end else if (op[7:6] == CPD_GRP_LOW && op[3:0] == CPD_LOW_PAIR_IMM
                   && op[5:4] != CPD_PAIR_AF) begin
         classify = CPD_OP_LOAD_PAIR_IMM;
      end else if (op[7:6] == CPD_GRP_HIGH && op[3:0] == CPD_LOW_PUSH) begin
         classify = (op[5:4] == CPD_PAIR_AF) ? CPD_OP_PUSH_AF : CPD_OP_PUSH_PAIR;
      end
   endfunction

   cpd_op_t     op_reg, op_next;
   logic        ov_reg, ov_next;
   logic [2:0]  dst_reg, dst_next, src_reg, src_next;
   logic [1:0]  pair_reg, pair_next, imm_reg, imm_next;

   // Opcode decode; fields follow the fixed register encoding
   always_comb begin
      ov_next   = i_op_valid;
      op_next   = op_reg;
      dst_next  = dst_reg;
      src_next  = src_reg;
      pair_next = pair_reg;
      imm_next  = imm_reg;
      if (i_op_valid) begin
         op_next   = classify(i_opcode);
         dst_next  = i_opcode[5:3];
         src_next  = i_opcode[2:0];
         pair_next = i_opcode[5:4];
         imm_next  = (op_next == CPD_OP_LOAD_PAIR_IMM) ? CPD_IMM_PAIR : 2'h0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         op_reg   <= CPD_OP_NONE;
         ov_reg   <= 1'b0;
         dst_reg  <= CPD_REG_B;
         src_reg  <= CPD_REG_B;
         pair_reg <= 2'h0;
         imm_reg  <= 2'h0;
      end else begin
         op_reg   <= op_next;
         ov_reg   <= ov_next;
         dst_reg  <= dst_next;
         src_reg  <= src_next;
         pair_reg <= pair_next;
         imm_reg  <= imm_next;
      end
   end

   assign o_op_valid  = ov_reg;
   assign o_op        = op_reg;
   assign o_dst       = dst_reg;
   assign o_src       = src_reg;
   assign o_pair      = pair_reg;
   assign o_imm_bytes = imm_reg;

   // Interrupt latches and service sequencer
   cpd_st_t     st_reg, st_next;
   logic        nmi_reg, nmi_next, r2_reg, r2_next;
   logic [15:0] vec_reg, vec_next, pd_reg, pd_next;
   logic        pv_reg, pv_next, jv_reg, jv_next;
   logic        nmi_req;
   cpd_src_t    win;

   always_comb begin
      nmi_req = nmi_reg && sif.level[0]; // Edge latched, must still be high
      // RST3, RST4 and the general request are only seen while held
      if (nmi_req)                        win = CPD_SRC_NMI;
      else if (!i_int_enable)             win = CPD_SRC_NONE;
      else if (r2_reg)                    win = CPD_SRC_RST2;
      else if (sif.level[2])              win = CPD_SRC_RST3;
      else if (sif.level[3])              win = CPD_SRC_RST4;
      else if (sif.level[4])              win = CPD_SRC_GEN;
      else                                win = CPD_SRC_NONE;
   end

   always_comb begin
      st_next  = st_reg;
      vec_next = vec_reg;
      pd_next  = pd_reg;
      pv_next  = 1'b0;
      jv_next  = 1'b0;
      // Set beats clear: a new edge in the service cycle re-arms the latch
      nmi_next = (nmi_reg && sif.level[0]) || sif.rise[0];
      r2_next  = r2_reg || sif.rise[1];
      case (st_reg)
         CPD_ST_IDLE: begin
            if (i_int_take && win != CPD_SRC_NONE) begin
               case (win)
                  CPD_SRC_NMI: begin
                     vec_next = CPD_VEC_NMI;
                     nmi_next = sif.rise[0]; // Only a fresh edge re-arms
                  end
                  CPD_SRC_RST2: begin
                     vec_next = CPD_VEC_RST2;
                     r2_next  = sif.rise[1];
                  end
                  CPD_SRC_RST3: vec_next = CPD_VEC_RST3;
                  CPD_SRC_RST4: vec_next = CPD_VEC_RST4;
                  default:      vec_next = vec_reg;
               endcase
               st_next = (win == CPD_SRC_GEN) ? CPD_ST_ACK : CPD_ST_PUSH;
            end
         end
         CPD_ST_ACK: begin
            // Target from the supplied opcode
            if (i_ack_valid) begin
               if ((i_ack_opcode & CPD_RST_MASK) == CPD_RST_CODE) begin
                  vec_next = rst_vec(i_ack_opcode);
               end else begin
                  vec_next = i_program_counter; // Non-restart: stay, sequencer handles
               end
               st_next = CPD_ST_PUSH;
            end
         end
         CPD_ST_PUSH: begin
            pd_next = i_program_counter;
            pv_next = 1'b1;
            st_next = CPD_ST_JUMP;
         end
         CPD_ST_JUMP: begin
            jv_next = 1'b1; // Only after the push
            st_next = CPD_ST_IDLE;
         end
         default: st_next = CPD_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         st_reg  <= CPD_ST_IDLE;
         vec_reg <= 16'h0000;
         pd_reg  <= 16'h0000;
         pv_reg  <= 1'b0;
         jv_reg  <= 1'b0;
         nmi_reg <= 1'b0;
         r2_reg  <= 1'b0;
      end else begin
         st_reg  <= st_next;
         vec_reg <= vec_next;
         pd_reg  <= pd_next;
         pv_reg  <= pv_next;
         jv_reg  <= jv_next;
         nmi_reg <= nmi_next;
         r2_reg  <= r2_next;
      end
   end

   assign o_int_pending = (st_reg == CPD_ST_IDLE) && (win != CPD_SRC_NONE);
   assign o_ack_req     = (st_reg == CPD_ST_ACK);
   assign o_push_valid  = pv_reg;
   assign o_push_data   = pd_reg;
   assign o_jump_valid  = jv_reg;
   assign o_jump_addr   = vec_reg;
endmodule

// File: test/cpd_decode_properties.sv
// Purpose: Port-level properties of the opcode and interrupt decoder
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every cpd_decode instance
`timescale 1ns/1ns
module cpd_decode_properties
   import cpd_pkg::*;
(
   input logic        i_clk,
   input logic        i_reset_n,
   input logic        i_op_valid,
   input logic [7:0]  i_opcode,
   input logic        i_int_take,
   input logic        i_ack_valid,
   input logic [7:0]  i_ack_opcode,
   input logic [15:0] i_program_counter,
   input logic        o_op_valid,
   input cpd_op_t     o_op,
   input logic [2:0]  o_dst,
   input logic [2:0]  o_src,
   input logic [1:0]  o_pair,
   input logic [1:0]  o_imm_bytes,
   input logic        o_int_pending,
   input logic        o_ack_req,
   input logic        o_push_valid,
   input logic [15:0] o_push_data,
   input logic        o_jump_valid,
   input logic [15:0] o_jump_addr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   logic [7:0] b;
   logic [7:0] pb;
   logic [7:0] ak;
   assign b = i_opcode;
   // Previous opcode; acknowledge byte held from its strobe until the branch
   always_ff @(posedge i_clk) begin
      pb <= b;
      if (i_ack_valid) begin
         ak <= i_ack_opcode;
      end
   end
   copy_decode_a: assert property (
      i_op_valid && b[7:6] == 2'h1 && b[5:3] != 3'h6 && b[2:0] != 3'h6 |=> o_op_valid
      && o_op == CPD_OP_COPY && o_dst == pb[5:3] && o_src == pb[2:0])
      else $error("copy decode wrong");
   store_decode_a: assert property (
      i_op_valid && b[7:3] == 5'h0E && b[2:0] != 3'h6
      |=> o_op == CPD_OP_STORE_M && o_src == pb[2:0]) else $error("store decode wrong");
   load_decode_a: assert property (
      i_op_valid && b[7:6] == 2'h1 && b[5:3] != 3'h6 && b[2:0] == 3'h6
      |=> o_op == CPD_OP_LOAD_M && o_dst == pb[5:3]) else $error("load decode wrong");
   pair_load_a: assert property (
      i_op_valid && b[7:6] == 2'h0 && b[3:0] == 4'h1 && b[5:4] != 2'h3
      |=> o_op == CPD_OP_LOAD_PAIR_IMM && o_pair == pb[5:4] && o_imm_bytes == 2'h2)
      else $error("pair load decode wrong");
   push_decode_a: assert property (
      i_op_valid && b[7:6] == 2'h3 && b[3:0] == 4'h5 |=> o_pair == pb[5:4]
      && o_op == (pb[5:4] == 2'h3 ? CPD_OP_PUSH_AF : CPD_OP_PUSH_PAIR))
      else $error("push decode wrong");
   push_counter_a: assert property (
      o_push_valid |-> o_push_data == $past(i_program_counter))
      else $error("pushed value wrong");
   jump_after_push_a: assert property (
      o_jump_valid |-> $past(o_push_valid)) else $error("branch without push");
   take_order_a: assert property (
      i_int_take && o_int_pending |=> o_ack_req or (##1 o_push_valid ##1 o_jump_valid))
      else $error("service order wrong");
   ack_vector_a: assert property (
      o_ack_req && i_ack_valid && (i_ack_opcode & CPD_RST_MASK) == CPD_RST_CODE
      |-> ##[1:3] (o_jump_valid && o_jump_addr == {10'h000, ak[5:3], 3'h0}))
      else $error("acknowledge vector wrong");
endmodule
bind cpd_decode cpd_decode_properties u_props (.i_clk, .i_reset_n, .i_op_valid, .i_opcode,
   .i_int_take, .i_ack_valid, .i_ack_opcode, .i_program_counter, .o_op_valid, .o_op, .o_dst,
   .o_src, .o_pair, .o_imm_bytes, .o_int_pending, .o_ack_req, .o_push_valid, .o_push_data,
   .o_jump_valid, .o_jump_addr);

// File: test/cpd_irq_src.sv
// Purpose: Interrupt sources and acknowledge responder facing the decoder
// Assumes: Pin order nmi, rst2, rst3, rst4, general
// Notes:   Acknowledge answered DLY+1 cycles after the request rises
`timescale 1ns/1ns
module cpd_irq_src #(parameter int DLY = 3) (
   input  logic        i_clk,
   input  logic [4:0]  i_raise,
   input  logic [4:0]  i_drop,
   input  logic        i_jump_valid,
   input  logic [15:0] i_jump_addr,
   input  logic        i_ack_req,
   input  logic [7:0]  i_vec_op,
   output logic [4:0]  o_pins,
   output logic        o_ack_valid,
   output logic [7:0]  o_ack_opcode
);
   logic [4:0] p;
   int         cnt = 0;
   initial o_pins = '0;
   initial o_ack_valid = 1'b0;
   // RST3 and RST4 drop once their branch shows they were served, the general request once acknowledged
   always @(posedge i_clk) begin
      p = (o_pins | i_raise) & ~i_drop;
      if (i_jump_valid && i_jump_addr == 16'h034C) p[2] = 1'b0;
      if (i_jump_valid && i_jump_addr == 16'h002C) p[3] = 1'b0;
      if (o_ack_valid) p[4] = 1'b0;
      o_pins <= p;
      cnt <= i_ack_req ? cnt + 1 : 0;
      o_ack_valid <= i_ack_req && !o_ack_valid && cnt == DLY;
   end
   // Stale byte outside the acknowledge so a late sample is caught
   assign o_ack_opcode = o_ack_valid ? i_vec_op : ~i_vec_op;
endmodule

// File: test/cpd_decode_tb_top.sv
// Purpose: Self-checking bench for the opcode and interrupt decoder
// Assumes: 50 ns clock, inputs driven 5 ns after the edge
// Notes:   Interrupt enable dropped once to show a masked request waiting
`timescale 1ns/1ns
module cpd_decode_tb_top;
   import cpd_pkg::*;
   logic        i_clk = 0, i_reset_n = 0, i_op_valid = 0, i_int_take = 0;
   logic [7:0]  i_opcode = '0, vec_op = 8'hEF, ack_op;
   logic [4:0]  raise = '0, drop = '0, pins;
   logic [15:0] prog_counter = 16'h5A3C, o_push_data, o_jump_addr;
   logic        int_en = 1'b1;
   logic        ack_valid, o_op_valid, o_int_pending, o_ack_req, o_push_valid, o_jump_valid;
   cpd_op_t     o_op;
   logic [2:0]  o_dst, o_src;
   logic [1:0]  o_pair, o_imm_bytes;
   int          n_mismatch = 0, cmp_count = 0, cyc = 0;
   always #25 i_clk = ~i_clk;
   cpd_decode u_dut (.i_clk, .i_reset_n, .i_op_valid, .i_opcode, .i_nmi(pins[0]),
      .i_rst2(pins[1]), .i_rst3(pins[2]), .i_rst4(pins[3]),
      .i_general_interrupt_request(pins[4]), .i_int_enable(int_en), .i_int_take,
      .i_ack_valid(ack_valid), .i_ack_opcode(ack_op), .i_program_counter(prog_counter),
      .o_op_valid,
      .o_op, .o_dst, .o_src, .o_pair, .o_imm_bytes, .o_int_pending, .o_ack_req,
      .o_push_valid, .o_push_data, .o_jump_valid, .o_jump_addr);
   cpd_irq_src #(.DLY(3)) u_src (.i_clk, .i_raise(raise), .i_drop(drop),
      .i_jump_valid(o_jump_valid), .i_jump_addr(o_jump_addr), .i_ack_req(o_ack_req),
      .i_vec_op(vec_op), .o_pins(pins), .o_ack_valid(ack_valid), .o_ack_opcode(ack_op));
   task step;
      @(posedge i_clk);
      #5;
   endtask
   task chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic cpd_op_t exp_op(input logic [7:0] c);
      if (c == 8'h76) return CPD_OP_HALT;
      if (c[7:6] == 2'h1) return c[5:3] == 3'h6 ? CPD_OP_STORE_M :
         (c[2:0] == 3'h6 ? CPD_OP_LOAD_M : CPD_OP_COPY);
      if (c[7:6] == 2'h0 && c[3:0] == 4'h1 && c[5:4] != 2'h3) return CPD_OP_LOAD_PAIR_IMM;
      if (c[7:6] == 2'h3 && c[3:0] == 4'h5) return c[5:4] == 2'h3 ? CPD_OP_PUSH_AF :
         CPD_OP_PUSH_PAIR;
      return CPD_OP_NONE;
   endfunction
   task pulse(input logic [4:0] r, input logic [4:0] d);
      raise = r;
      drop = d;
      step;
      raise = '0;
      drop = '0;
   endtask
   // Settle synchronisers, take, then watch push and branch
   task take_chk(input logic [15:0] v);
      int n;
      logic pushed;
      n = 0;
      pushed = 1'b0;
      repeat (6) step;
      while (o_int_pending !== 1'b1 && n < 20) begin step; n++; end
      i_int_take = 1'b1;
      step;
      i_int_take = 1'b0;
      while (o_jump_valid !== 1'b1 && n < 40) begin
         if (o_push_valid === 1'b1) pushed = o_push_data === prog_counter;
         step;
         n++;
      end
      chk(pushed && o_jump_addr === v, "interrupt branch");
   endtask
   // Every opcode back to back
   task t_decode;
      cpd_op_t e;
      for (int i = 0; i < 256; i++) begin
         i_op_valid = 1'b1;
         i_opcode = i[7:0];
         e = exp_op(i[7:0]);
         step;
         chk(o_op_valid === 1'b1 && o_op === e, "decode kind");
         chk(o_dst === i_opcode[5:3] && o_src === i_opcode[2:0], "fields");
         chk(o_pair === i_opcode[5:4], "decode pair");
         chk(o_imm_bytes === (e == CPD_OP_LOAD_PAIR_IMM ? 2'h2 : 2'h0), "imm");
      end
      i_op_valid = 1'b0;
   endtask
   // Counter changes between takes so a stale push shows
   task t_pri;
      pulse(5'h0C, 5'h00);
      take_chk(16'h034C);
      prog_counter = 16'hA5C3;
      take_chk(16'h002C);
   endtask
   // Masked level request waits while held, then is served
   task t_mask;
      int_en = 1'b0;
      pulse(5'h08, 5'h00);
      repeat (8) step;
      chk(o_int_pending === 1'b0, "masked request pending");
      int_en = 1'b1;
      take_chk(16'h002C);
   endtask
   task t_nmi;
      pulse(5'h03, 5'h00);
      repeat (8) step;
      pulse(5'h00, 5'h02);
      take_chk(16'h0024);
      take_chk(16'h003C);
      repeat (8) step;
      chk(o_int_pending === 1'b0, "held top request retaken");
      pulse(5'h00, 5'h01);
   endtask
   task t_gen;
      pulse(5'h10, 5'h00);
      take_chk(16'h0028);
      // Non-restart supplied byte falls back to the counter
      vec_op = 8'h3E;
      prog_counter = 16'h0F0F;
      pulse(5'h10, 5'h00);
      take_chk(16'h0F0F);
   endtask
   // Hang guard
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge i_clk);
      #5 i_reset_n = 1'b1;
      t_decode();
      t_pri();
      t_nmi();
      t_mask();
      t_gen();
      summarize();
   end
endmodule
